// ===== src/diag_defines.vh
/*
 * constants of the diagnosis parameter bank: register offsets, reset values,
 * jog command codes and output function codes.
 * assumes it is included by bare name from the bank's design files.
 */
`ifndef DIAG_DEFINES_VH
`define DIAG_DEFINES_VH

// ==========================================================
// register offsets (16-bit parameter word addresses)
`define ADDR_HIST_NEWEST  16'h0400
`define ADDR_HIST_SECOND  16'h0402
`define ADDR_HIST_THIRD   16'h0404
`define ADDR_HIST_FOURTH  16'h0406
`define ADDR_HIST_FIFTH   16'h0408
`define ADDR_JOG_COMMAND  16'h040a
`define ADDR_OUT_FORCE    16'h040c
`define ADDR_SOFT_INPUT   16'h040e

// ==========================================================
// reset values
`define RST_HISTORY       32'h0000_0000
`define RST_JOG_COMMAND   16'h0014
`define RST_OUT_FORCE     16'h0000
`define RST_SOFT_INPUT    16'h0000

// ==========================================================
// jog command codes
`define JOG_STOP          16'h0000
`define JOG_CCW           16'h1386
`define JOG_CW            16'h1387
`define JOG_SPEED_MAX     16'h1388

// ==========================================================
// output function codes
`define OUT_CODE_BASE     8'h30
`define OUT_CODE_LAST     8'h3f
`define FIRST_OUT_FOLLOW  16'h0130

// ==========================================================
// fault record field layout
`define REC_ALARM_LSB     0
`define REC_BUSERR_LSB    16

`endif

// ===== src/fault_history_mem.v
/*
 * five-deep fault history shift store, newest first.
 * assumes a single clock and an active-low asynchronous reset; read data
 * leave through a register one cycle after the address is given.
 */
`timescale 1ns/1ps
`include "diag_defines.vh"

module fault_history_mem #(
	parameter DEPTH = 5
) (
	// clock and reset
	input  wire        ref_clk,
	input  wire        nrst,
	// new record in
	input  wire        push,
	input  wire [31:0] rec_in,
	// read port
	input  wire [2:0]  rd_slot,
	output reg  [31:0] rd_data
);

	reg [31:0] slot_q [0:DEPTH-1]; // slot 0 is newest
	integer    i;

	// ==========================================================
	// shift on every new fault, oldest falls out
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			for (i = 0; i < DEPTH; i = i + 1) begin
				slot_q[i] <= `RST_HISTORY;
			end
		end else if (push) begin
			slot_q[0] <= rec_in;
			for (i = 1; i < DEPTH; i = i + 1) begin
				slot_q[i] <= slot_q[i-1];
			end
		end
	end

	// ==========================================================
	// registered read, out of range reads zero
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rd_data <= 32'h0000_0000;
		end else if (rd_slot < DEPTH) begin
			rd_data <= slot_q[rd_slot];
		end else begin
			rd_data <= 32'h0000_0000;
		end
	end

endmodule

// ===== src/diag_param_bank.v
/*
 * diagnosis parameter bank: fault history, jog command, forced output bits
 * and software input bits, reached over a simple parameter word port.
 * assumes the link layer delivers one-cycle write strobes and read
 * requests synchronous to ref_clk; keypad keys are already debounced.
 */
`timescale 1ns/1ps
`include "diag_defines.vh"

module diag_param_bank #(
	parameter DI_COUNT = 5
) (
	// clock and reset
	input  wire                ref_clk,
	input  wire                nrst,
	// parameter port
	input  wire                par_wr,
	input  wire                par_rd,
	input  wire [15:0]         par_addr,
	input  wire                par_hi,
	input  wire [15:0]         par_wdata,
	output reg  [15:0]         par_rdata,
	output reg                 par_rvalid,
	output reg                 par_err,
	// fault event
	input  wire                fault_event,
	input  wire [15:0]         alarm_number,
	input  wire [15:0]         bus_error_code,
	// keypad
	input  wire                keypad_jog_mode,
	input  wire                key_up,
	input  wire                key_down,
	// motor limits and jog outputs
	input  wire [15:0]         motor_max_speed,
	output reg                 jog_run_q,
	output reg                 jog_dir_pos_q,
	output reg  [15:0]         jog_speed_q,
	// digital outputs
	input  wire [15:0]         first_output_assignment,
	output reg  [15:0]         out_code_bits_q,
	output reg                 first_output_q,
	// digital inputs
	input  wire [DI_COUNT-1:0] di_terminal,
	input  wire [DI_COUNT-1:0] input_source_select,
	output reg  [DI_COUNT-1:0] di_combined_q
);

	// ==========================================================
	// functions
	function speed_ok; // legal speed code
		input [15:0] v;
		begin
			speed_ok = (v != `JOG_STOP) && (v <= `JOG_SPEED_MAX) &&
				(v != `JOG_CCW) && (v != `JOG_CW);
		end
	endfunction

	function [15:0] cap_speed; // limit to motor maximum
		input [15:0] v;
		input [15:0] mx;
		begin
			cap_speed = (v > mx) ? mx : v;
		end
	endfunction

	// ==========================================================
	// registers
	reg [15:0] jog_command_q;   // last jog word
	reg [15:0] jog_set_q;       // held speed setting
	reg [15:0] soft_input_q;    // software input bits
	reg        comm_jog_q;      // communication jog active
	reg        comm_dir_q;      // 1 = cw (positive)
	reg        rd_pend_q;       // history read in flight
	reg        rd_hi_q;         // which half of the record
	reg [2:0]  rd_slot;         // decoded history slot
	reg        hist_hit;        // address falls in history
	wire [31:0] hist_data;      // registered history word

	// ==========================================================
	// history store
	fault_history_mem #(
		.DEPTH(5)
	) u_hist (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.push    (fault_event),
		.rec_in  ({bus_error_code, alarm_number}),
		.rd_slot (rd_slot),
		.rd_data (hist_data)
	);

	// ==========================================================
	// history address decode
	always @* begin
		hist_hit = 1'b0;
		rd_slot  = 3'd7;
		case (par_addr)
			`ADDR_HIST_NEWEST: begin hist_hit = 1'b1; rd_slot = 3'd0; end
			`ADDR_HIST_SECOND: begin hist_hit = 1'b1; rd_slot = 3'd1; end
			`ADDR_HIST_THIRD:  begin hist_hit = 1'b1; rd_slot = 3'd2; end
			`ADDR_HIST_FOURTH: begin hist_hit = 1'b1; rd_slot = 3'd3; end
			`ADDR_HIST_FIFTH:  begin hist_hit = 1'b1; rd_slot = 3'd4; end
			default: begin
				hist_hit = 1'b0;
				rd_slot  = 3'd7;
			end
		endcase
	end

	// ==========================================================
	// parameter writes
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			jog_command_q   <= `RST_JOG_COMMAND;
			jog_set_q       <= `RST_JOG_COMMAND;
			out_code_bits_q <= `RST_OUT_FORCE;
			soft_input_q    <= `RST_SOFT_INPUT;
			comm_jog_q      <= 1'b0;
			comm_dir_q      <= 1'b0;
		end else if (par_wr && !par_hi) begin
			case (par_addr)
				`ADDR_JOG_COMMAND: begin
					jog_command_q <= par_wdata;
					if (par_wdata == `JOG_CCW) begin
						comm_jog_q <= 1'b1;
						comm_dir_q <= 1'b0;
					end else if (par_wdata == `JOG_CW) begin
						comm_jog_q <= 1'b1;
						comm_dir_q <= 1'b1;
					end else if (par_wdata == `JOG_STOP) begin
						comm_jog_q <= 1'b0;
					end else if (speed_ok(par_wdata)) begin
						jog_set_q <= par_wdata;
					end else begin
						comm_jog_q <= 1'b0;
					end
				end
				`ADDR_OUT_FORCE: begin
					out_code_bits_q <= par_wdata;
				end
				`ADDR_SOFT_INPUT: begin
					soft_input_q <= par_wdata;
				end
				default: begin
					soft_input_q <= soft_input_q;
				end
			endcase
		end
	end

	// ==========================================================
	// jog drive: in keypad mode the keys act only while held; outside keypad mode comm jog
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			jog_run_q     <= 1'b0;
			jog_dir_pos_q <= 1'b0;
			jog_speed_q   <= 16'h0000;
		end else begin
			jog_speed_q <= cap_speed(jog_set_q, motor_max_speed);
			if (!speed_ok(jog_set_q)) begin
				jog_run_q <= 1'b0;
			end else if (keypad_jog_mode) begin
				jog_run_q     <= key_up ^ key_down;
				jog_dir_pos_q <= key_up;
			end else begin
				jog_run_q     <= comm_jog_q;
				jog_dir_pos_q <= comm_dir_q;
			end
		end
	end

	// ==========================================================
	// outputs and input combination
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			first_output_q <= 1'b0;
			di_combined_q  <= {DI_COUNT{1'b0}};
		end else begin
			first_output_q <= (first_output_assignment == `FIRST_OUT_FOLLOW) ?
				out_code_bits_q[0] : 1'b0;
			di_combined_q <= (input_source_select & soft_input_q[DI_COUNT-1:0]) |
				(~input_source_select & di_terminal);
		end
	end

	// ==========================================================
	// read path: history answers one cycle later, rest at once
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			par_rdata  <= 16'h0000;
			par_rvalid <= 1'b0;
			par_err    <= 1'b0;
			rd_pend_q  <= 1'b0;
			rd_hi_q    <= 1'b0;
		end else begin
			par_rvalid <= 1'b0;
			par_err    <= 1'b0;
			rd_pend_q  <= 1'b0;
			if (rd_pend_q) begin
				par_rdata  <= rd_hi_q ? hist_data[31:16] : hist_data[15:0];
				par_rvalid <= 1'b1;
			end else if (par_rd) begin
				if (hist_hit) begin
					rd_pend_q <= 1'b1;
					rd_hi_q   <= par_hi;
				end else begin
					par_rvalid <= 1'b1;
					case (par_addr)
						`ADDR_JOG_COMMAND: par_rdata <= par_hi ? 16'h0000 : jog_command_q;
						`ADDR_OUT_FORCE:   par_rdata <= par_hi ? 16'h0000 : out_code_bits_q;
						`ADDR_SOFT_INPUT: begin
							par_rdata <= par_hi ? 16'h0000 :
								{{(16-DI_COUNT){1'b0}}, di_combined_q};
						end
						default: begin
							par_rdata <= 16'h0000;
							par_err   <= 1'b1;
						end
					endcase
				end
			end
		end
	end

endmodule

// ===== test/diag_param_bank_assertions.sv
/* checker for the diagnosis parameter bank, bound onto its top ports.
   assumes ref_clk is the only clock and nrst is active low. */
`timescale 1ns/1ps
`include "diag_defines.vh"
module diag_param_bank_chk (
	// link side
	input wire        ref_clk,
	input wire        nrst,
	input wire        par_wr,
	input wire        par_rd,
	input wire [15:0] par_addr,
	input wire [15:0] par_wdata,
	input wire        par_rvalid,
	input wire        par_err,
	// drive side
	input wire        keypad_jog_mode,
	input wire        key_up,
	input wire        key_down,
	input wire [15:0] motor_max_speed,
	input wire        jog_run_q,
	input wire        jog_dir_pos_q,
	input wire [15:0] jog_speed_q,
	input wire [15:0] first_output_assignment,
	input wire [15:0] out_code_bits_q,
	input wire        first_output_q
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// ========================================
	// sequences and properties
	// jog word written over the link outside keypad mode
	sequence s_jog(w);
		par_wr && par_addr == `ADDR_JOG_COMMAND && par_wdata == w && !keypad_jog_mode;
	endsequence
	// keypad keys held for two cycles
	sequence s_keys(u, d);
		(keypad_jog_mode && key_up == u && key_down == d)[*2];
	endsequence
	// first pin in follow mode while the force bits sit still
	sequence s_follow;
		(first_output_assignment == `FIRST_OUT_FOLLOW && $stable(out_code_bits_q))[*2];
	endsequence
	AST_HIST_LATENCY: assert property (par_rd && par_addr == `ADDR_HIST_NEWEST
		|-> ##2 par_rvalid && !par_err) else $error("history answer late");
	AST_JOG_CW: assert property (s_jog(`JOG_CW) |-> ##2 jog_run_q && jog_dir_pos_q)
		else $error("cw jog not started");
	AST_JOG_STOP: assert property (s_jog(`JOG_STOP) |-> ##2 !jog_run_q)
		else $error("jog not stopped");
	AST_SPEED_CAP: assert property ($stable(motor_max_speed)
		|-> jog_speed_q <= motor_max_speed) else $error("jog speed above cap");
	AST_KEY_UP: assert property (s_keys(1'b1, 1'b0) |-> jog_run_q && jog_dir_pos_q)
		else $error("up key gives no positive jog");
	AST_KEY_DOWN: assert property (s_keys(1'b0, 1'b1) |-> jog_run_q && !jog_dir_pos_q)
		else $error("down key gives no negative jog");
	AST_KEY_RELEASE: assert property (s_keys(1'b0, 1'b0) |-> !jog_run_q)
		else $error("jog runs after key release");
	AST_FIRST_OUT: assert property (s_follow |-> first_output_q == out_code_bits_q[0])
		else $error("first pin not following bit 0");
endmodule

// ===== test/host_model.sv
/* host model: parameter link master with one-cycle strobes.
   assumes the bench supplies ref_clk; requests change at falling edges. */
`timescale 1ns/1ps
module host_model (
	// clock and answers
	input  wire        ref_clk,
	input  wire [15:0] par_rdata,
	input  wire        par_rvalid,
	input  wire        par_err,
	// requests
	output reg         par_wr = 1'b0,
	output reg         par_rd = 1'b0,
	output reg  [15:0] par_addr = 16'h0000,
	output reg         par_hi = 1'b0,
	output reg  [15:0] par_wdata = 16'h0000
);
	// one paced write; the strobe stands for one edge, then the data are inverted
	task wr(input [15:0] a, input [15:0] d);
		@(negedge ref_clk);
		{par_wr, par_addr, par_hi, par_wdata} = {1'b1, a, 1'b0, d};
		@(negedge ref_clk);
		{par_wr, par_wdata} = {1'b0, ~d};
	endtask
	// one read; the strobe stands for one edge, the address stays put, and the
	// answer is looked at mid-cycle while it stands, four cycles at most
	task rd(input [15:0] a, input h, output [15:0] q, output e, output ok);
		ok = 1'b0;
		@(negedge ref_clk);
		{par_rd, par_addr, par_hi} = {1'b1, a, h};
		repeat (4) begin
			@(negedge ref_clk);
			par_rd = 1'b0;
			if (par_rvalid === 1'b1 && !ok) {q, e, ok} = {par_rdata, par_err, 1'b1};
		end
	endtask
endmodule

// ===== test/testbench.sv
/* bench for the diagnosis parameter bank; host model on the link.
   assumes src/ is on the include path. */
`timescale 1ns/1ps
`include "diag_defines.vh"
module testbench;
	// bench inputs
	reg         ref_clk = 1'b0, nrst = 1'b0, fault_event = 1'b0;
	reg         keypad_jog_mode = 1'b0, key_up = 1'b0, key_down = 1'b0;
	reg  [15:0] alarm_number = 16'h0000, bus_error_code = 16'h0000;
	reg  [15:0] motor_max_speed = 16'h0bb8, first_output_assignment = 16'h0000;
	reg  [4:0]  di_terminal = 5'h1a, input_source_select = 5'h0f;
	// link and outputs
	wire        par_wr, par_rd, par_hi, par_rvalid, par_err, jog_run_q, jog_dir_pos_q;
	wire        first_output_q;
	wire [15:0] par_addr, par_wdata, par_rdata, jog_speed_q, out_code_bits_q;
	wire [4:0]  di_combined_q;
	integer     n_fail = 0, checked = 0;
	initial forever #12.5 ref_clk = ~ref_clk;
	host_model host_model_inst (.*);
	diag_param_bank diag_param_bank_inst (.*);
	// compare and count
	task chk(input [31:0] got, input [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// verdict and end of run
	task results;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// read, compare error flag and word; a missing answer ends the run
	task rdc(input [15:0] a, input h, input [15:0] x, input e);
		reg [15:0] q;
		reg        ge, ok;
		host_model_inst.rd(a, h, q, ge, ok);
		if (ok !== 1'b1) begin
			n_fail++;
			results;
		end
		chk({15'h0, ge, q}, {15'h0, e, x});
	endtask
	// jog word by link (w) or keys, then compare run and direction
	task jx(input w, input [15:0] d, input [1:0] x);
		if (w) host_model_inst.wr(`ADDR_JOG_COMMAND, d);
		else {key_up, key_down} = d[1:0];
		repeat (3) @(negedge ref_clk);
		chk({30'h0, jog_run_q, jog_dir_pos_q}, {30'h0, x});
	endtask
	task t_reset;
		rdc(`ADDR_HIST_FIFTH, 1'b1, 16'h0000, 1'b0);
		rdc(`ADDR_JOG_COMMAND, 1'b0, `RST_JOG_COMMAND, 1'b0);
		rdc(`ADDR_OUT_FORCE, 1'b0, `RST_OUT_FORCE, 1'b0);
		rdc(16'h0410, 1'b0, 16'h0000, 1'b1);
		$display("reset test done");
	endtask
	// six back-to-back faults, then every slot newest first
	task t_hist;
		reg [15:0] k;
		for (k = 16'h0001; k < 16'h0007; k++) begin
			@(negedge ref_clk);
			{fault_event, alarm_number, bus_error_code} = {1'b1, k, k + 16'h0100};
		end
		@(negedge ref_clk);
		fault_event = 1'b0;
		for (k = 16'h0000; k < 16'h0005; k++) begin
			rdc(16'h0400 + {k[14:0], 1'b0}, 1'b0, 16'h0006 - k, 1'b0);
			rdc(16'h0400 + {k[14:0], 1'b0}, 1'b1, 16'h0106 - k, 1'b0);
		end
		$display("history test done");
	endtask
	task t_jog;
		motor_max_speed = 16'h0032;
		jx(1'b1, `JOG_CW, 2'b11);
		jx(1'b1, `JOG_CCW, 2'b10);
		jx(1'b1, `JOG_STOP, 2'b00);
		jx(1'b1, 16'h0064, 2'b00);
		chk({16'h0, jog_speed_q}, 32'h0000_0032);
		jx(1'b1, `JOG_CCW, 2'b10);
		jx(1'b1, 16'h1770, 2'b00);
		keypad_jog_mode = 1'b1;
		jx(1'b0, 16'h0002, 2'b11);
		jx(1'b0, 16'h0001, 2'b10);
		jx(1'b0, 16'h0000, 2'b00);
		keypad_jog_mode = 1'b0;
		$display("jog test done");
	endtask
	task t_io;
		first_output_assignment = `FIRST_OUT_FOLLOW;
		host_model_inst.wr(`ADDR_OUT_FORCE, 16'h8001);
		repeat (3) @(negedge ref_clk);
		chk({15'h0, out_code_bits_q, first_output_q}, {15'h0, 16'h8001, 1'b1});
		first_output_assignment = 16'h0131;
		repeat (2) @(negedge ref_clk);
		chk({31'h0, first_output_q}, 32'h0000_0000);
		first_output_assignment = `FIRST_OUT_FOLLOW;
		host_model_inst.wr(`ADDR_SOFT_INPUT, 16'h0005);
		repeat (3) @(negedge ref_clk);
		chk({27'h0, di_combined_q}, 32'h0000_0015);
		rdc(`ADDR_SOFT_INPUT, 1'b0, 16'h0015, 1'b0);
		$display("io test done");
	endtask
	initial begin
		repeat (2) @(negedge ref_clk);
		nrst = 1'b1;
		t_reset;
		t_hist;
		t_jog;
		t_io;
		results;
	end
endmodule
bind diag_param_bank diag_param_bank_chk diag_param_bank_chk_inst (.*);
